// *** src/tsc_pkg.sv ***
/*
  tsc_pkg: register map, field layout, reset values, codes and timing
  constants of the touch sensor control and status block.
  Assumes a 40 MHz system clock.
*/
package tsc_pkg;

  // =========================================================
  // register offsets
  localparam logic [7:0] OFS_GEN_CTRL_ONE     = 8'h08;
  localparam logic [7:0] OFS_GEN_CTRL_TWO     = 8'h09;
  localparam logic [7:0] OFS_REF_RENEW_LOW    = 8'h0a;
  localparam logic [7:0] OFS_REF_RENEW_HIGH   = 8'h0b;
  localparam logic [7:0] OFS_CH_FREEZE_LOW    = 8'h0c;
  localparam logic [7:0] OFS_CH_FREEZE_HIGH   = 8'h0d;
  localparam logic [7:0] OFS_CAL_DIS_LOW      = 8'h0e;
  localparam logic [7:0] OFS_CAL_DIS_HIGH     = 8'h0f;
  localparam logic [7:0] OFS_TOUCH_CH1_4      = 8'h10;
  localparam logic [7:0] OFS_TOUCH_CH5_8      = 8'h11;
  localparam logic [7:0] OFS_TOUCH_CH9_12     = 8'h12;

  // =========================================================
  // reset values and writable masks
  localparam logic [7:0] RST_GEN_CTRL_ONE     = 8'h23;
  localparam logic [7:0] RST_GEN_CTRL_TWO     = 8'h04;
  localparam logic [7:0] RST_REF_RENEW_LOW    = 8'hfe;
  localparam logic [7:0] RST_REF_RENEW_HIGH   = 8'h0f;
  localparam logic [7:0] RST_CH_FREEZE_LOW    = 8'hfe;
  localparam logic [7:0] RST_CH_FREEZE_HIGH   = 8'h0f;
  localparam logic [7:0] RST_CAL_DIS_LOW      = 8'h00;
  localparam logic [7:0] RST_CAL_DIS_HIGH     = 8'h00;
  localparam logic [7:0] MASK_GEN_CTRL_TWO    = 8'h0f;
  localparam logic [7:0] MASK_HIGH_CHANNELS   = 8'h0f;
  localparam logic [7:0] READ_UNMAPPED        = 8'h00;

  // =========================================================
  // field positions
  localparam int MODE_BIT    = 7;
  localparam int WIN_HI      = 6;
  localparam int WIN_LO      = 5;
  localparam int LVL_HI      = 4;
  localparam int LVL_LO      = 3;
  localparam int RTC_HI      = 2;
  localparam int RTC_LO      = 0;
  localparam int SOFT_RST_BIT = 3;
  localparam int SLEEP_BIT   = 2;
  localparam int NUM_CH      = 12;

  // =========================================================
  // codes
  localparam logic [1:0] CODE_NONE   = 2'h0;
  localparam logic [1:0] CODE_LOW    = 2'h1;
  localparam logic [1:0] CODE_MIDDLE = 2'h2;
  localparam logic [1:0] CODE_HIGH   = 2'h3;
  localparam logic [1:0] LVL_ANY     = 2'h1;
  localparam logic [1:0] LVL_HIGH    = 2'h3;

  // =========================================================
  // timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned UNIT_TIME_MSEC = 10;
  localparam int unsigned UNIT_CYCLES    = CLK_HZ / 1000 * UNIT_TIME_MSEC;
  localparam int unsigned WIN_STEP_S     = 5;
  localparam int unsigned WIN_STEP_UNITS = WIN_STEP_S * 1000 / UNIT_TIME_MSEC;
  localparam logic [5:0]  RTC_ADD        = 6'h02;
  localparam int unsigned SLEEP_SHIFT    = 2;

  typedef enum logic {CAL_WINDOW, CAL_RUN} tsc_cal_state_t;

endpackage : tsc_pkg

// *** src/tsc_divider.sv ***
/*
  tsc_divider: one-cycle enable pulse every LIMIT clocks.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tsc_divider
  import tsc_pkg::*;
#(
  parameter int unsigned LIMIT = UNIT_CYCLES
) (
  input  wire logic clk_in,     // system clock
  input  wire logic reset_in,   // sync reset, high
  output logic      tick_out    // one-cycle pulse
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 32'h1;
    if (cnt_r == 32'(LIMIT - 1)) begin
      cnt_nxt  = 32'h0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_r    <= 32'h0;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end

endmodule // tsc_divider

// *** src/tsc_channel.sv ***
/*
  tsc_channel: touch code holder of one sensing channel.
  Assumes the front end sample is stable at the period tick.
*/
`timescale 1ns/1ps
module tsc_channel
  import tsc_pkg::*;
(
  input  wire logic       clk_in,          // system clock
  input  wire logic       reset_in,        // sync reset, high
  input  wire logic       period_tick_in,  // response period end
  input  wire logic       freeze_in,       // channel held
  input  wire logic [1:0] sample_in,       // front end intensity
  output logic      [1:0] code_out         // reported code
);

  logic [1:0] code_nxt;

  always_comb begin
    code_nxt = code_out;
    if (freeze_in) begin
      code_nxt = CODE_NONE;
    end else if (period_tick_in) begin
      code_nxt = sample_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      code_out <= CODE_NONE;
    end else begin
      code_out <= code_nxt;
    end
  end

  a_freeze_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    freeze_in |=> code_out == CODE_NONE)
    else $error("held channel kept a code");

  a_code_steady: assert property (@(posedge clk_in) disable iff (reset_in)
    !period_tick_in && !freeze_in |=> $stable(code_out))
    else $error("code changed outside a period end");

endmodule // tsc_channel

// *** src/tsc_top.sv ***
/*
  tsc_top: control and status logic of a 12-channel touch sensor.
  Assumes a serial register front end delivering byte accesses,
  and an analog front end taking the enables and giving 2-bit samples.
*/
`timescale 1ns/1ps
module tsc_top
  import tsc_pkg::*;
#(
  parameter int unsigned UNIT_LIMIT = UNIT_CYCLES
) (
  input  wire logic        clk_in,          // 40 MHz clock
  input  wire logic        reset_in,        // reset pin, high
  input  wire logic [7:0]  reg_addr_in,     // register address
  input  wire logic [7:0]  reg_wdata_in,    // write data
  input  wire logic        reg_wr_in,       // write strobe
  input  wire logic        reg_rd_in,       // read strobe
  output logic      [7:0]  reg_rdata_out,   // read data
  input  wire logic        sync_option_in,  // option pin level
  input  wire logic [23:0] sample_in,       // front end codes
  output logic      [11:0] sense_en_out,    // channel sensing on
  output logic      [11:0] calib_en_out,    // channel calibration on
  output logic      [11:0] ref_renew_out,   // channel reference renew
  output logic             cal_fast_out,    // fast calibration rate
  output logic             sleep_out,       // low current mode
  output logic             single_mode_out, // single output mode
  output logic             irq_oe_out,      // interrupt pin pulls low
  output logic             out1_oe_out      // channel 1 pin pulls low
);

  // =========================================================
  // register file
  logic [7:0] ctrl_one_r, ctrl_one_nxt;
  logic [7:0] ctrl_two_r, ctrl_two_nxt;
  logic [7:0] renew_lo_r, renew_lo_nxt;
  logic [7:0] renew_hi_r, renew_hi_nxt;
  logic [7:0] frz_lo_r, frz_lo_nxt;
  logic [7:0] frz_hi_r, frz_hi_nxt;
  logic [7:0] cdis_lo_r, cdis_lo_nxt;
  logic [7:0] cdis_hi_r, cdis_hi_nxt;
  logic [7:0] rdata_nxt;
  logic [23:0] codes;
  logic [23:0] shown;

  always_comb begin
    ctrl_one_nxt = ctrl_one_r;
    ctrl_two_nxt = ctrl_two_r;
    renew_lo_nxt = renew_lo_r;
    renew_hi_nxt = renew_hi_r;
    frz_lo_nxt   = frz_lo_r;
    frz_hi_nxt   = frz_hi_r;
    cdis_lo_nxt  = cdis_lo_r;
    cdis_hi_nxt  = cdis_hi_r;
    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_GEN_CTRL_ONE:   ctrl_one_nxt = reg_wdata_in;
        // reserved bits stay zero whatever the host writes
        OFS_GEN_CTRL_TWO:   ctrl_two_nxt = reg_wdata_in & MASK_GEN_CTRL_TWO;
        OFS_REF_RENEW_LOW:  renew_lo_nxt = reg_wdata_in;
        OFS_REF_RENEW_HIGH: renew_hi_nxt = reg_wdata_in & MASK_HIGH_CHANNELS;
        OFS_CH_FREEZE_LOW:  frz_lo_nxt   = reg_wdata_in;
        OFS_CH_FREEZE_HIGH: frz_hi_nxt   = reg_wdata_in & MASK_HIGH_CHANNELS;
        OFS_CAL_DIS_LOW:    cdis_lo_nxt  = reg_wdata_in;
        OFS_CAL_DIS_HIGH:   cdis_hi_nxt  = reg_wdata_in & MASK_HIGH_CHANNELS;
        default:            ctrl_one_nxt = ctrl_one_r;
      endcase
    end
    rdata_nxt = reg_rdata_out;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_GEN_CTRL_ONE:   rdata_nxt = ctrl_one_r;
        OFS_GEN_CTRL_TWO:   rdata_nxt = ctrl_two_r;
        OFS_REF_RENEW_LOW:  rdata_nxt = renew_lo_r;
        OFS_REF_RENEW_HIGH: rdata_nxt = renew_hi_r;
        OFS_CH_FREEZE_LOW:  rdata_nxt = frz_lo_r;
        OFS_CH_FREEZE_HIGH: rdata_nxt = frz_hi_r;
        OFS_CAL_DIS_LOW:    rdata_nxt = cdis_lo_r;
        OFS_CAL_DIS_HIGH:   rdata_nxt = cdis_hi_r;
        OFS_TOUCH_CH1_4:    rdata_nxt = shown[7:0];
        OFS_TOUCH_CH5_8:    rdata_nxt = shown[15:8];
        OFS_TOUCH_CH9_12:   rdata_nxt = shown[23:16];
        default:            rdata_nxt = READ_UNMAPPED;
      endcase
    end
  end

  // registers sit with the serial block: only the pin resets them
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_one_r    <= RST_GEN_CTRL_ONE;
      ctrl_two_r    <= RST_GEN_CTRL_TWO;
      renew_lo_r    <= RST_REF_RENEW_LOW;
      renew_hi_r    <= RST_REF_RENEW_HIGH;
      frz_lo_r      <= RST_CH_FREEZE_LOW;
      frz_hi_r      <= RST_CH_FREEZE_HIGH;
      cdis_lo_r     <= RST_CAL_DIS_LOW;
      cdis_hi_r     <= RST_CAL_DIS_HIGH;
      reg_rdata_out <= READ_UNMAPPED;
    end else begin
      ctrl_one_r    <= ctrl_one_nxt;
      ctrl_two_r    <= ctrl_two_nxt;
      renew_lo_r    <= renew_lo_nxt;
      renew_hi_r    <= renew_hi_nxt;
      frz_lo_r      <= frz_lo_nxt;
      frz_hi_r      <= frz_hi_nxt;
      cdis_lo_r     <= cdis_lo_nxt;
      cdis_hi_r     <= cdis_hi_nxt;
      reg_rdata_out <= rdata_nxt;
    end
  end

  // =========================================================
  // decoded fields
  logic        logic_rst;
  logic        mode_fast;
  logic [1:0]  win_sel;
  logic [1:0]  lvl_sel;
  logic [2:0]  rtc;
  logic        sleep;
  logic [11:0] freeze;
  logic [11:0] cal_dis;
  logic [11:0] renew;

  assign logic_rst = reset_in | ctrl_two_r[SOFT_RST_BIT];
  assign mode_fast = ctrl_one_r[MODE_BIT];
  assign win_sel   = ctrl_one_r[WIN_HI:WIN_LO];
  assign lvl_sel   = ctrl_one_r[LVL_HI:LVL_LO];
  assign rtc       = ctrl_one_r[RTC_HI:RTC_LO];
  assign sleep     = ctrl_two_r[SLEEP_BIT];
  assign freeze    = {frz_hi_r[3:0], frz_lo_r};
  assign cal_dis   = {cdis_hi_r[3:0], cdis_lo_r};
  assign renew     = {renew_hi_r[3:0], renew_lo_r};

  // =========================================================
  // time base and response period
  logic       unit_tick;
  logic [5:0] period_len;
  logic [5:0] per_cnt_r, per_cnt_nxt;
  logic       period_tick;

  tsc_divider #(
    .LIMIT (UNIT_LIMIT)
  ) u_unit_div (
    .clk_in   (clk_in),
    .reset_in (logic_rst),
    .tick_out (unit_tick)
  );

  always_comb begin
    period_len = 6'({3'h0, rtc}) + RTC_ADD;
    if (sleep) begin
      period_len = 6'(period_len << SLEEP_SHIFT);
    end
    per_cnt_nxt = per_cnt_r;
    period_tick = 1'b0;
    if (unit_tick) begin
      if (per_cnt_r >= period_len - 6'h1) begin
        per_cnt_nxt = 6'h0;
        period_tick = 1'b1;
      end else begin
        per_cnt_nxt = per_cnt_r + 6'h1;
      end
    end
  end

  // =========================================================
  // power-on fast calibration window
  tsc_cal_state_t cal_state_r, cal_state_nxt;
  logic [11:0]    win_cnt_r, win_cnt_nxt;
  logic [11:0]    win_len;
  logic           alt_r, alt_nxt;

  always_comb begin
    win_len       = 12'(({10'h0, win_sel} + 12'h1) * 12'(WIN_STEP_UNITS));
    cal_state_nxt = cal_state_r;
    win_cnt_nxt   = win_cnt_r;
    alt_nxt       = alt_r;
    case (cal_state_r)
      CAL_WINDOW: begin
        if (unit_tick) begin
          if (win_cnt_r >= win_len - 12'h1) begin
            cal_state_nxt = CAL_RUN;
          end else begin
            win_cnt_nxt = win_cnt_r + 12'h1;
          end
        end
      end
      CAL_RUN: begin
        if (period_tick) begin
          alt_nxt = ~alt_r;
        end
      end
      default: cal_state_nxt = CAL_WINDOW;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (logic_rst) begin
      per_cnt_r   <= 6'h0;
      cal_state_r <= CAL_WINDOW;
      win_cnt_r   <= 12'h0;
      alt_r       <= 1'b0;
    end else begin
      per_cnt_r   <= per_cnt_nxt;
      cal_state_r <= cal_state_nxt;
      win_cnt_r   <= win_cnt_nxt;
      alt_r       <= alt_nxt;
    end
  end

  // =========================================================
  // channels
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    tsc_channel u_ch (
      .clk_in         (clk_in),
      .reset_in       (logic_rst),
      .period_tick_in (period_tick),
      .freeze_in      (freeze[i]),
      .sample_in      (sample_in[2*i+1:2*i]),
      .code_out       (codes[2*i+1:2*i])
    );
  end

  // single mode reports only the lowest touched channel;
  // interrupt judged on the codes loading at this period end
  logic        found;
  logic        found_new;
  logic        hit;
  logic [23:0] fresh;
  always_comb begin
    shown     = codes;
    fresh     = sample_in;
    found     = 1'b0;
    found_new = 1'b0;
    hit       = 1'b0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (freeze[k]) begin
        fresh[2*k +: 2] = CODE_NONE;
      end
      if (single_mode_out && found) begin
        shown[2*k +: 2] = CODE_NONE;
      end
      if (single_mode_out && found_new) begin
        fresh[2*k +: 2] = CODE_NONE;
      end
      found     = found | (codes[2*k +: 2] != CODE_NONE);
      found_new = found_new | (fresh[2*k +: 2] != CODE_NONE);
    end
    for (int k = 0; k < NUM_CH; k++) begin
      case (lvl_sel)
        LVL_ANY:  hit = hit | (fresh[2*k +: 2] >= CODE_LOW);
        LVL_HIGH: hit = hit | (fresh[2*k +: 2] == CODE_HIGH);
        default:  hit = hit | (fresh[2*k +: 2] >= CODE_MIDDLE);
      endcase
    end
  end

  // =========================================================
  // outputs to pins and front end
  logic irq_nxt;
  always_comb begin
    irq_nxt = irq_oe_out;
    if (period_tick) begin
      irq_nxt = hit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (logic_rst) begin
      sense_en_out    <= 12'h000;
      calib_en_out    <= 12'h000;
      ref_renew_out   <= 12'h000;
      cal_fast_out    <= 1'b1;
      sleep_out       <= 1'b0;
      single_mode_out <= 1'b0;
      irq_oe_out      <= 1'b0;
      out1_oe_out     <= 1'b0;
    end else begin
      sense_en_out    <= ~freeze;
      calib_en_out    <= ~freeze & ~cal_dis;
      ref_renew_out   <= renew & ~freeze;
      cal_fast_out    <= mode_fast | (cal_state_nxt == CAL_WINDOW) | alt_nxt;
      sleep_out       <= sleep;
      single_mode_out <= sync_option_in;
      irq_oe_out      <= irq_nxt;
      out1_oe_out     <= (codes[1:0] != CODE_NONE);
    end
  end

  // =========================================================
  // checks
  sequence s_unit_end;
    unit_tick && per_cnt_r == period_len - 6'h1;
  endsequence

  a_period_len: assert property (@(posedge clk_in) disable iff (logic_rst)
    s_unit_end |-> period_tick)
    else $error("period end missed");

  a_irq_steady: assert property (@(posedge clk_in) disable iff (logic_rst)
    !period_tick |=> $stable(irq_oe_out))
    else $error("interrupt moved between period ends");

  a_irq_high: assert property (@(posedge clk_in) disable iff (logic_rst)
    period_tick && lvl_sel == LVL_HIGH && ((fresh & (fresh >> 1) & 24'h555555) == 24'h0)
      |=> !irq_oe_out)
    else $error("interrupt without a high code in high-only level");

  a_soft_reset: assert property (@(posedge clk_in)
    ctrl_two_r[SOFT_RST_BIT] |=> codes == 24'h0 && !irq_oe_out && cal_state_r == CAL_WINDOW)
    else $error("soft reset did not clear logic");

  a_pin_reset: assert property (@(posedge clk_in)
    reset_in |=> ctrl_one_r == RST_GEN_CTRL_ONE && renew_lo_r == RST_REF_RENEW_LOW)
    else $error("pin reset left registers");

  a_fast_mode: assert property (@(posedge clk_in) disable iff (logic_rst)
    mode_fast ##1 mode_fast |-> cal_fast_out)
    else $error("fast mode not held");

  a_window_fast: assert property (@(posedge clk_in) disable iff (logic_rst)
    cal_state_r == CAL_WINDOW ##1 cal_state_r == CAL_WINDOW |-> cal_fast_out)
    else $error("slow calibration inside window");

  a_cal_gate: assert property (@(posedge clk_in) disable iff (logic_rst)
    cal_dis[8] && !freeze[8] ##1 cal_dis[8] && !freeze[8]
      |-> sense_en_out[8] && !calib_en_out[8])
    else $error("calibration disable not applied");

  a_single_mode: assert property (@(posedge clk_in) disable iff (logic_rst)
    sync_option_in |=> single_mode_out)
    else $error("option pin not followed");

  a_pack_order: assert property (@(posedge clk_in) disable iff (logic_rst)
    reg_rd_in && reg_addr_in == OFS_TOUCH_CH9_12 |=> reg_rdata_out == $past(shown[23:16]))
    else $error("third status register packing wrong");

endmodule // tsc_top

// *** sim/tsc_host_model.sv ***
/*
  tsc_host_model: host side of the byte register port of tsc_top.
  Assumes clk_in from the bench; requests launch 1 ns after a rising edge.
*/
`timescale 1ns/1ps
module tsc_host_model (
  input  wire logic       clk_in,    // system clock
  input  wire logic [7:0] rdata_in,  // read data
  output logic      [7:0] addr_out,  // register address
  output logic      [7:0] wdata_out, // write data
  output logic            wr_out,    // write strobe
  output logic            rd_out     // read strobe
);
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // ==========================================================
  // bus cycles
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out   = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    d      = rdata_in;
  endtask
  // low bits forced to 11, reserved bits zero
  task automatic init_ctrl_two(input logic sleep_bit);
    reg_write(8'h09, {4'h0, 1'b0, sleep_bit, 2'b11});
  endtask
endmodule // tsc_host_model

// *** sim/tb_tsc_top.sv ***
/*
  tb_tsc_top: register and sensing tests of tsc_top.
  Assumes UNIT_LIMIT of 4 clocks; front end codes driven by the bench.
*/
`timescale 1ns/1ps
module tb_tsc_top;
  import tsc_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, sync_option_pin;
  logic [23:0] sample;
  logic [11:0] sense_en, calib_en, ref_renew;
  logic        cal_fast, sleep, single, irq_oe, out1_oe;
  int          n_errors, check_count, cyc, n;
  logic [7:0]  rst_tab [11] = '{8'h23, 8'h04, 8'hfe, 8'h0f, 8'hfe, 8'h0f,
                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  tsc_top #(.UNIT_LIMIT(4)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sync_option_in(sync_option_pin),
    .sample_in(sample), .sense_en_out(sense_en), .calib_en_out(calib_en),
    .ref_renew_out(ref_renew), .cal_fast_out(cal_fast), .sleep_out(sleep),
    .single_mode_out(single), .irq_oe_out(irq_oe), .out1_oe_out(out1_oe));
  tsc_host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  // ==========================================================
  // comparisons and closing
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 45000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // helpers
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.reg_read(a, d);
    chk_byte(d, exp);
  endtask
  task automatic wait_irq(input logic lvl, output int k);
    k = 0;
    while (irq_oe !== lvl && k < 1000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
  endtask
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
  endtask
  // ==========================================================
  // tests
  initial begin
    reset_in = 1'b1;
    sync_option_pin = 1'b0;
    sample   = 24'h000000;
    do_reset();
    for (int i = 0; i < 11; i++) rd_chk(8'h08 + 8'(i), rst_tab[i]);
    rd_chk(8'h20, READ_UNMAPPED);
    chk_bit(cal_fast, 1'b1);
    chk_bit(sleep, 1'b1);
    chk_vec(sense_en, 12'h001);
    chk_vec(ref_renew, 12'h000);
    host.init_ctrl_two(1'b0);
    wait_cyc(2);
    chk_bit(sleep, 1'b0);
    rd_chk(8'h09, 8'h03);
    host.reg_write(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'h0f);
    host.reg_write(8'h10, 8'hff);
    rd_chk(8'h10, 8'h00);
    host.reg_write(8'h0c, 8'h00);
    host.reg_write(8'h0d, 8'h00);
    host.reg_write(8'h0f, 8'h0f);
    wait_cyc(2);
    chk_vec(sense_en, 12'hfff);
    chk_vec(calib_en, 12'h0ff);
    chk_vec(ref_renew, 12'hffe);
    host.reg_write(8'h08, 8'h88);
    sample = 24'hd8e41b;
    wait_cyc(40);
    rd_chk(8'h10, 8'h1b);
    rd_chk(8'h11, 8'he4);
    rd_chk(8'h12, 8'hd8);
    chk_bit(out1_oe, 1'b1);
    host.reg_write(8'h0c, 8'h01);
    wait_cyc(40);
    rd_chk(8'h10, 8'h18);
    chk_bit(out1_oe, 1'b0);
    host.reg_write(8'h0c, 8'h00);
    sync_option_pin = 1'b1;
    sample   = 24'hd8e410;
    wait_cyc(40);
    chk_bit(single, 1'b1);
    rd_chk(8'h10, 8'h10);
    rd_chk(8'h11, 8'h00);
    sync_option_pin = 1'b0;
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < 4; c++) begin
        host.reg_write(8'h08, {3'b100, 2'(l), 3'b000});
        sample = {12{2'(c)}};
        wait_cyc(30);
        chk_bit(irq_oe, (l == 1) ? (c >= 1) : (l == 3) ? (c == 3) : (c >= 2));
      end
    end
    host.reg_write(8'h08, 8'h87);
    for (int s = 0; s < 2; s++) begin
      host.init_ctrl_two(s[0]);
      sample = {12{CODE_HIGH}};
      wait_irq(1'b1, n);
      sample = {12{CODE_NONE}};
      wait_irq(1'b0, n);
      sample = {12{CODE_HIGH}};
      wait_irq(1'b1, n);
      chk_vec(n[11:0], (s == 1) ? 12'h090 : 12'h024);
    end
    host.init_ctrl_two(1'b0);
    for (int f = 0; f < 4; f++) begin
      host.reg_write(8'h09, 8'h0b);
      host.reg_write(8'h08, {1'b0, 2'(f), 5'b00011});
      wait_cyc(10);
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h08, {1'b0, 2'(f), 5'b00011});
      host.reg_write(8'h09, 8'h03);
      n = 0;
      while (cal_fast !== 1'b0 && n < 10000) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      chk_bit(n >= (f + 1) * 2000 - 8 && n <= (f + 1) * 2000 + 48, 1'b1);
    end
    host.reg_write(8'h09, 8'h0b);
    host.reg_write(8'h08, 8'h83);
    host.reg_write(8'h09, 8'h03);
    wait_cyc(2300);
    chk_bit(cal_fast, 1'b1);
    do_reset();
    rd_chk(8'h09, 8'h04);
    rd_chk(8'h0c, 8'hfe);
    end_of_test();
  end
endmodule // tb_tsc_top
